//--- mts_consts.vh
// Register map, field positions, reset values and timing for the sequencer
`ifndef MTS_CONSTS_VH
`define MTS_CONSTS_VH

`define MTS_A_CTRL      8'h00
`define MTS_A_CMD       8'h04
`define MTS_A_TIMER     8'h08
`define MTS_A_DELAY     8'h0c
`define MTS_A_SAMP      8'h10
`define MTS_A_TRIG      8'h14
`define MTS_A_PULSE     8'h18
`define MTS_A_STATUS    8'h1c

`define MTS_C_CONT      0
`define MTS_C_SRC_LO    1
`define MTS_C_SRC_HI    3
`define MTS_C_EXTMODE   4
`define MTS_C_REMOTE    5
`define MTS_C_RCLCONT   6

`define MTS_K_INIT      0
`define MTS_K_ABORT     1
`define MTS_K_RECALL    2
`define MTS_K_PRESET    3
`define MTS_K_RESET     4
`define MTS_K_BUSTRIG   5
`define MTS_K_SIGNAL    6

`define MTS_S_INITERR   8
`define MTS_S_SAMPERR   9

`define MTS_SRC_A       3'h0
`define MTS_SRC_MANUAL  3'h1
`define MTS_SRC_TIMER   3'h2
`define MTS_SRC_EXT     3'h3
`define MTS_SRC_BUS     3'h4

`define MTS_RST_TIMER   30'h00000064
`define MTS_RST_DELAY   30'h00000000
`define MTS_RST_SAMP    16'h0001
`define MTS_RST_TRIG    16'h0001
`define MTS_RST_PULSE   8'h04
`define MTS_MAX_MS      30'd999999999

`define MTS_TICK_NS     1000000
`define MTS_CLK_NS      8

`endif

//--- mts_sync.v
// Two-flop synchroniser for one asynchronous input
`default_nettype none

module mts_sync
(
	input  wire aclk,
	input  wire aresetn,
	input  wire d,
	output reg  q
);

	reg meta_q;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= 1'b1;
			q      <= 1'b1;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

//--- mts_trigger_sequencer.v
// Measurement trigger sequencer with AXI4-Lite register access
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`default_nettype none
`include "mts_consts.vh"

// Notes on behaviour
// - Front-panel external mode accepts three trigger sources
// - Each key press takes one reading
// - Mode key again returns to free-running triggering
// - Line one completion out, line two trigger in
// - Interlock low blocks all input triggers; here it gates link and DIO only, not the key
// - External trigger recognised on falling edge
// - Completion pulse, then wait for next trigger
// - Idle performs no measurement or step
// - Abort, recall, preset, reset return to idle
// - Leave idle at once if continuous
// - Preset enables continuous, reset disables it
// - Recall restarts only if recalled continuous
// - Initiate or continuous-on leaves idle
// - Source A satisfies detection at once
// - Manual source uses key, local mode only
// - Timer bypassed on first pass only
// - Later timer passes wait max(timer, delay)
// - Timer range 0..999999.999 s, reset at idle
// - External uses link trigger, bus uses command
// - Sample counter inner, trigger counter outer loop
// - Samples above one stored, repeats overwrite
// - One output pulse per sample set
// - Programmable delay before device action
// - Initiate while running ignored, flags error
// - Continuous on rejects sample count above one
module mts_trigger_sequencer
#(
	parameter TICK_CYCLES = `MTS_TICK_NS / `MTS_CLK_NS
)
(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        ext_trig_link_n,
	input  wire        dio_trig_n,
	input  wire        interlock_in,
	input  wire        trig_key,
	input  wire        external_trigger_mode_key,
	output reg         measure_complete_output,
	output reg         meas_start,
	input  wire        meas_done,
	output reg         buf_wr,
	output reg  [15:0] buf_addr
);

	localparam S_IDLE  = 3'd0;
	localparam S_WAIT  = 3'd1;
	localparam S_DELAY = 3'd2;
	localparam S_ACT   = 3'd3;
	localparam S_MEAS  = 3'd4;
	localparam S_OUT   = 3'd5;

	wire        link_s;
	wire        dio_s;
	wire        ilk_s;
	wire        key_s;
	wire        mkey_s;
	reg         link_d_q;
	reg         dio_d_q;
	reg         key_d_q;
	reg         mkey_d_q;

	reg  [7:0]  aw_addr_q;
	reg         aw_full_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         w_full_q;

	reg         cont_q;
	reg  [2:0]  src_q;
	reg         ext_mode_q;
	reg         remote_q;
	reg         rcl_cont_q;
	reg  [29:0] timer_q;
	reg  [29:0] delay_q;
	reg  [15:0] samp_cnt_q;
	reg  [15:0] trig_cnt_q;
	reg  [7:0]  pulse_w_q;
	reg  [6:0]  cmd_q;
	reg         init_err_q;
	reg         samp_err_q;

	reg  [2:0]  state_q;
	reg         first_q;
	reg  [15:0] samp_idx_q;
	reg  [15:0] trig_idx_q;
	reg  [29:0] wait_q;
	reg  [31:0] div_q;
	reg  [7:0]  pcnt_q;

	wire        do_wr;
	wire [31:0] wmask;
	wire [31:0] wval;
	wire [31:0] ctrl_rd;
	wire [31:0] stat_rd;
	wire        link_fall;
	wire        dio_fall;
	wire        key_rise;
	wire        mkey_rise;
	wire        ext_any;
	wire        restart;
	wire        tick;
	wire [29:0] tmax;
	wire [31:0] timer_nx;
	wire [31:0] delay_nx;
	reg         fire;
	reg         wr_ok;

	mts_sync u_sync_link (.aclk(aclk), .aresetn(aresetn),
		.d(ext_trig_link_n), .q(link_s));
	mts_sync u_sync_dio (.aclk(aclk), .aresetn(aresetn),
		.d(dio_trig_n), .q(dio_s));
	mts_sync u_sync_ilk (.aclk(aclk), .aresetn(aresetn),
		.d(interlock_in), .q(ilk_s));
	mts_sync u_sync_key (.aclk(aclk), .aresetn(aresetn),
		.d(~trig_key), .q(key_s));
	mts_sync u_sync_mkey (.aclk(aclk), .aresetn(aresetn),
		.d(~external_trigger_mode_key), .q(mkey_s));

	// Key inputs are inverted into the synchroniser so reset reads released
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link_d_q <= 1'b1;
			dio_d_q  <= 1'b1;
			key_d_q  <= 1'b1;
			mkey_d_q <= 1'b1;
		end
		else
		begin
			link_d_q <= link_s;
			dio_d_q  <= dio_s;
			key_d_q  <= key_s;
			mkey_d_q <= mkey_s;
		end
	end

	assign link_fall = link_d_q & ~link_s;
	assign dio_fall  = dio_d_q & ~dio_s;
	assign key_rise  = key_d_q & ~key_s;
	assign mkey_rise = mkey_d_q & ~mkey_s;
	// Interlock high or open enables; the pin needs a pull-up outside
	assign ext_any   = ilk_s & (link_fall | dio_fall);

	assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign ctrl_rd = {25'h0000000, rcl_cont_q, remote_q, ext_mode_q,
		src_q, cont_q};
	assign stat_rd = {samp_idx_q, 6'h00, samp_err_q, init_err_q,
		5'h00, state_q};

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	assign wval = merge(32'h00000000, w_data_q, wmask);
	assign timer_nx = merge({2'b00, timer_q}, w_data_q, wmask);
	assign delay_nx = merge({2'b00, delay_q}, w_data_q, wmask);

	always @*
	begin
		case (aw_addr_q)
			`MTS_A_CTRL, `MTS_A_CMD, `MTS_A_TIMER, `MTS_A_DELAY,
			`MTS_A_SAMP, `MTS_A_TRIG, `MTS_A_PULSE, `MTS_A_STATUS:
				wr_ok = 1'b1;
			default:
				wr_ok = 1'b0;
		endcase
	end

	// Write channel and register file
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			cont_q        <= 1'b0;
			src_q         <= `MTS_SRC_A;
			ext_mode_q    <= 1'b0;
			remote_q      <= 1'b0;
			rcl_cont_q    <= 1'b0;
			timer_q       <= `MTS_RST_TIMER;
			delay_q       <= `MTS_RST_DELAY;
			samp_cnt_q    <= `MTS_RST_SAMP;
			trig_cnt_q    <= `MTS_RST_TRIG;
			pulse_w_q     <= `MTS_RST_PULSE;
			cmd_q         <= 7'h00;
			init_err_q    <= 1'b0;
			samp_err_q    <= 1'b0;
		end
		else
		begin
			cmd_q <= 7'h00;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_q     <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (mkey_rise)
				ext_mode_q <= ~ext_mode_q;
			if (do_wr)
			begin
				aw_full_q     <= 1'b0;
				w_full_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= wr_ok ? 2'b00 : 2'b10;
				case (aw_addr_q)
					`MTS_A_CTRL:
					begin
						if (w_strb_q[0])
						begin
							cont_q     <= w_data_q[`MTS_C_CONT];
							src_q      <= w_data_q[`MTS_C_SRC_HI:`MTS_C_SRC_LO];
							ext_mode_q <= w_data_q[`MTS_C_EXTMODE];
							remote_q   <= w_data_q[`MTS_C_REMOTE];
							rcl_cont_q <= w_data_q[`MTS_C_RCLCONT];
						end
					end
					`MTS_A_CMD:
					begin
						cmd_q <= wval[6:0];
						if (wval[`MTS_K_PRESET])
						begin
							cont_q     <= 1'b1;
							trig_cnt_q <= 16'h0000;
						end
						else if (wval[`MTS_K_RESET])
						begin
							cont_q     <= 1'b0;
							trig_cnt_q <= `MTS_RST_TRIG;
							samp_cnt_q <= `MTS_RST_SAMP;
							src_q      <= `MTS_SRC_A;
							timer_q    <= `MTS_RST_TIMER;
							delay_q    <= `MTS_RST_DELAY;
							ext_mode_q <= 1'b0;
						end
						else if (wval[`MTS_K_RECALL])
							cont_q <= rcl_cont_q;
					end
					`MTS_A_TIMER:
						timer_q <= (timer_nx > {2'b00, `MTS_MAX_MS}) ?
							`MTS_MAX_MS : timer_nx[29:0];
					`MTS_A_DELAY:
						delay_q <= (delay_nx > {2'b00, `MTS_MAX_MS}) ?
							`MTS_MAX_MS : delay_nx[29:0];
					`MTS_A_SAMP:
					begin
						if (cont_q && wval[15:0] > 16'h0001)
							samp_err_q <= 1'b1;
						else if (wval[15:0] != 16'h0000)
							samp_cnt_q <= wval[15:0];
					end
					`MTS_A_TRIG:
						trig_cnt_q <= wval[15:0];
					`MTS_A_PULSE:
						if (wval[7:0] != 8'h00)
							pulse_w_q <= wval[7:0];
					`MTS_A_STATUS:
					begin
						if (wval[`MTS_S_INITERR])
							init_err_q <= 1'b0;
						if (wval[`MTS_S_SAMPERR])
							samp_err_q <= 1'b0;
					end
					default:
						cmd_q <= 7'h00;
				endcase
			end
			// Set after clear so a same-cycle event is kept
			if (cmd_q[`MTS_K_INIT] && state_q != S_IDLE)
				init_err_q <= 1'b1;
		end
	end

	// Read channel; unmapped addresses answer SLVERR with zero data
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
		else if (s_axi_arvalid)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'b00;
			case (s_axi_araddr)
				`MTS_A_CTRL:   s_axi_rdata <= ctrl_rd;
				`MTS_A_CMD:    s_axi_rdata <= 32'h00000000;
				`MTS_A_TIMER:  s_axi_rdata <= {2'b00, timer_q};
				`MTS_A_DELAY:  s_axi_rdata <= {2'b00, delay_q};
				`MTS_A_SAMP:   s_axi_rdata <= {16'h0000, samp_cnt_q};
				`MTS_A_TRIG:   s_axi_rdata <= {16'h0000, trig_cnt_q};
				`MTS_A_PULSE:  s_axi_rdata <= {24'h000000, pulse_w_q};
				`MTS_A_STATUS: s_axi_rdata <= stat_rd;
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
	end

	assign restart = cmd_q[`MTS_K_ABORT] | cmd_q[`MTS_K_RECALL] |
		cmd_q[`MTS_K_PRESET] | cmd_q[`MTS_K_RESET];
	assign tick = (div_q == TICK_CYCLES - 1);
	assign tmax = (timer_q > delay_q) ? timer_q : delay_q;

	// Event detection for the selected control source
	always @*
	begin
		if (ext_mode_q)
			fire = ext_any | key_rise;
		else
		begin
			case (src_q)
				`MTS_SRC_A:      fire = 1'b1;
				`MTS_SRC_MANUAL: fire = key_rise & ~remote_q;
				`MTS_SRC_TIMER:  fire = 1'b1;
				`MTS_SRC_EXT:    fire = ext_any;
				`MTS_SRC_BUS:    fire = cmd_q[`MTS_K_BUSTRIG];
				default:         fire = 1'b0;
			endcase
		end
		if (cmd_q[`MTS_K_SIGNAL])
			fire = 1'b1;
	end

	// Sequencer: wait, delay, sample loop, completion pulse, trigger loop
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q                 <= S_IDLE;
			first_q                 <= 1'b1;
			samp_idx_q              <= 16'h0000;
			trig_idx_q              <= 16'h0000;
			wait_q                  <= 30'h00000000;
			div_q                   <= 32'h00000000;
			pcnt_q                  <= 8'h00;
			meas_start              <= 1'b0;
			measure_complete_output <= 1'b0;
			buf_wr                  <= 1'b0;
			buf_addr                <= 16'h0000;
		end
		else
		begin
			buf_wr <= 1'b0;
			div_q  <= tick ? 32'h00000000 : div_q + 32'h00000001;
			// Pulse runs its full width even when a command cuts the pass
			if (pcnt_q != 8'h00)
				pcnt_q <= pcnt_q - 8'h01;
			if (pcnt_q == 8'h01)
				measure_complete_output <= 1'b0;
			if (restart)
			begin
				state_q                 <= S_IDLE;
				meas_start              <= 1'b0;
			end
			else
			begin
				case (state_q)
					S_IDLE:
					begin
						first_q    <= 1'b1;
						samp_idx_q <= 16'h0000;
						trig_idx_q <= 16'h0000;
						if (cont_q || ext_mode_q || cmd_q[`MTS_K_INIT])
							state_q <= S_WAIT;
					end
					S_WAIT:
						if (fire)
						begin
							state_q <= S_DELAY;
							div_q   <= 32'h00000000;
							if (src_q == `MTS_SRC_TIMER && !first_q &&
								!ext_mode_q)
								wait_q <= tmax;
							else
								wait_q <= delay_q;
						end
					S_DELAY:
						if (wait_q == 30'h00000000)
							state_q <= S_ACT;
						else if (tick)
							wait_q <= wait_q - 30'h00000001;
					S_ACT:
					begin
						meas_start <= 1'b1;
						state_q    <= S_MEAS;
					end
					S_MEAS:
					begin
						meas_start <= 1'b0;
						if (meas_done)
						begin
							if (samp_cnt_q > 16'h0001)
							begin
								buf_wr   <= 1'b1;
								buf_addr <= samp_idx_q;
							end
							samp_idx_q <= samp_idx_q + 16'h0001;
							if (samp_idx_q + 16'h0001 < samp_cnt_q)
								state_q <= S_ACT;
							else
							begin
								state_q                 <= S_OUT;
								pcnt_q                  <= pulse_w_q;
								measure_complete_output <= 1'b1;
							end
						end
					end
					S_OUT:
						if (pcnt_q == 8'h01)
						begin
							first_q                 <= 1'b0;
							samp_idx_q              <= 16'h0000;
							trig_idx_q <= trig_idx_q + 16'h0001;
							if (ext_mode_q || trig_cnt_q == 16'h0000 ||
								trig_idx_q + 16'h0001 < trig_cnt_q)
								state_q <= S_WAIT;
							else
								state_q <= S_IDLE;
						end
					default:
						state_q <= S_IDLE;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

//--- mts_far_model.sv
// Far-side model: reading engine and a scanner on the trigger link
`default_nettype none
module mts_far_model
#(
	parameter LAT = 8
)
(
	input  wire logic aclk,
	input  wire logic meas_start,
	input  wire logic measure_complete_output,
	input  wire logic fire,
	input  wire logic chain,
	output var  logic meas_done,
	output wire logic ext_trig_link_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	logic [2:0] low_q;
	logic       mco_q;
	initial
	begin
		meas_done = 1'b0;
		wait_q = 4'h0;
		low_q = 3'h0;
		mco_q = 1'b0;
	end
	// Idle high; held low long enough to pass the synchroniser
	assign ext_trig_link_n = (low_q == 3'h0);
	always @(posedge aclk)
	begin
		mco_q <= measure_complete_output;
		meas_done <= (wait_q == 4'h1);
		if (meas_start)
			wait_q <= 4'(LAT);
		else if (wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
		// Scanner answers when the completion pulse ends; a trigger sent
		// while the sequencer is still in its output phase would be lost
		if (fire || (chain && !measure_complete_output && mco_q))
			low_q <= 3'h5;
		else if (low_q != 3'h0)
			low_q <= low_q - 3'h1;
	end
endmodule
`default_nettype wire

//--- mts_trigger_sequencer_monitor.sv
// Port checker for the trigger sequencer
`default_nettype none
module mts_trigger_sequencer_monitor
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        meas_start,
	input wire logic        meas_done,
	input wire logic        measure_complete_output,
	input wire logic        buf_wr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_start_single: assert property (meas_start |=> !meas_start)
		else $error("start pulse too long");
	a_pulse_width: assert property ($rose(measure_complete_output) |->
		measure_complete_output[*4] ##1 !measure_complete_output)
		else $error("completion pulse width wrong");
	a_pulse_cause: assert property ($rose(measure_complete_output) |->
		$past(meas_done))
		else $error("completion without finished reading");
	a_pulse_no_start: assert property (measure_complete_output |->
		!meas_start)
		else $error("reading started during completion");
	a_store_single: assert property (buf_wr |=> !buf_wr)
		else $error("store pulse too long");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	cover property ($rose(measure_complete_output));
	cover property (buf_wr);
	cover property (meas_start ##[1:20] meas_done);
endmodule
bind mts_trigger_sequencer mts_trigger_sequencer_monitor u_mon
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .meas_start(meas_start),
	.meas_done(meas_done), .measure_complete_output(measure_complete_output),
	.buf_wr(buf_wr)
);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the trigger sequencer
`default_nettype none
`include "mts_consts.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, interlock, key;
	logic        fire, chain, link_n, mco, start, done, buf_wr;
	logic        dio_n, mkey;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv, n_start, n_pulse, n_wr, n_wr0;
	logic [1:0]  bresp, rresp, rr;
	logic [15:0] buf_addr;
	logic        mco_q;
	int          failures, compares;
	mts_trigger_sequencer #(.TICK_CYCLES(10)) uut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_trig_link_n(link_n), .dio_trig_n(dio_n),
		.interlock_in(interlock), .trig_key(key),
		.external_trigger_mode_key(mkey), .measure_complete_output(mco),
		.meas_start(start), .meas_done(done), .buf_wr(buf_wr),
		.buf_addr(buf_addr)
	);
	mts_far_model far
	(
		.aclk(aclk), .meas_start(start), .measure_complete_output(mco),
		.fire(fire), .chain(chain), .meas_done(done),
		.ext_trig_link_n(link_n)
	);
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		mco_q <= mco;
		// Outputs are unknown before the first reset edge
		if (aresetn)
		begin
			n_start <= n_start + 32'(start);
			n_pulse <= n_pulse + 32'(mco && !mco_q);
			n_wr <= n_wr + 32'(buf_wr);
			n_wr0 <= n_wr0 + 32'(buf_wr && buf_addr == 16'h0000);
		end
	end
	task automatic summarize;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	task automatic idle;
		int n;
		n = 0;
		do
		begin
			rd(`MTS_A_STATUS);
			n++;
		end
		while (rv[2:0] !== 3'h0 && n < 40);
		check({29'h0, rv[2:0]}, 32'h0);
	endtask
	task automatic zero;
		// Cleared between edges so the counting process never races it
		@(negedge aclk);
		{n_start, n_pulse, n_wr, n_wr0} = '0;
	endtask
	task automatic t_defaults;
		rd(`MTS_A_SAMP);
		check(rv, 32'h1);
		rd(`MTS_A_TIMER);
		check(rv, 32'h64);
		rd(`MTS_A_PULSE);
		check(rv, 32'h4);
		rd(8'h40);
		check({30'h0, rr}, 32'h2);
		check(n_start, 32'h0);
		$display("test defaults done");
	endtask
	task automatic t_source_a;
		zero;
		wr(`MTS_A_CMD, 32'h1);
		wr(`MTS_A_CMD, 32'h1);
		rd(`MTS_A_STATUS);
		check({31'h0, rv[8]}, 32'h1);
		idle;
		check(n_start, 32'h1);
		check(n_pulse, 32'h1);
		wr(`MTS_A_STATUS, 32'h100);
		$display("test source_a done");
	endtask
	task automatic t_samples;
		zero;
		wr(`MTS_A_SAMP, 32'h3);
		wr(`MTS_A_TRIG, 32'h2);
		wr(`MTS_A_CMD, 32'h1);
		idle;
		check(n_start, 32'h6);
		check(n_pulse, 32'h2);
		check(n_wr, 32'h6);
		check(n_wr0, 32'h2);
		wr(`MTS_A_SAMP, 32'h1);
		$display("test samples done");
	endtask
	task automatic t_external;
		zero;
		wr(`MTS_A_TRIG, 32'h3);
		wr(`MTS_A_CTRL, 32'h6);
		wr(`MTS_A_CMD, 32'h1);
		interlock <= 1'b0;
		repeat (4) @(posedge aclk);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (20) @(posedge aclk);
		check(n_start, 32'h0);
		interlock <= 1'b1;
		chain <= 1'b1;
		repeat (4) @(posedge aclk);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		idle;
		chain <= 1'b0;
		check(n_start, 32'h3);
		check(n_pulse, 32'h3);
		wr(`MTS_A_TRIG, 32'h1);
		$display("test external done");
	endtask
	task automatic t_bus_manual;
		zero;
		wr(`MTS_A_CTRL, 32'h8);
		wr(`MTS_A_CMD, 32'h1);
		repeat (20) @(posedge aclk);
		check(n_start, 32'h0);
		wr(`MTS_A_CMD, 32'h20);
		idle;
		check(n_start, 32'h1);
		wr(`MTS_A_CTRL, 32'h22);
		wr(`MTS_A_CMD, 32'h1);
		key <= 1'b1;
		repeat (6) @(posedge aclk);
		key <= 1'b0;
		repeat (20) @(posedge aclk);
		check(n_start, 32'h1);
		wr(`MTS_A_CMD, 32'h2);
		idle;
		wr(`MTS_A_CTRL, 32'h2);
		wr(`MTS_A_CMD, 32'h1);
		key <= 1'b1;
		repeat (6) @(posedge aclk);
		key <= 1'b0;
		idle;
		check(n_start, 32'h2);
		$display("test bus and manual done");
	endtask
	task automatic t_continuous;
		wr(`MTS_A_CTRL, 32'h0);
		zero;
		wr(`MTS_A_CMD, 32'h8);
		repeat (40) @(posedge aclk);
		check({31'h0, n_start > 32'h1}, 32'h1);
		wr(`MTS_A_SAMP, 32'h5);
		rd(`MTS_A_STATUS);
		check({31'h0, rv[9]}, 32'h1);
		rd(`MTS_A_SAMP);
		check(rv, 32'h1);
		wr(`MTS_A_CMD, 32'h10);
		idle;
		zero;
		repeat (20) @(posedge aclk);
		check(n_start, 32'h0);
		$display("test continuous done");
	endtask
	task automatic t_ext_mode;
		zero;
		mkey <= 1'b1;
		repeat (6) @(posedge aclk);
		mkey <= 1'b0;
		rd(`MTS_A_CTRL);
		check({31'h0, rv[4]}, 32'h1);
		dio_n <= 1'b0;
		repeat (6) @(posedge aclk);
		dio_n <= 1'b1;
		repeat (30) @(posedge aclk);
		key <= 1'b1;
		repeat (6) @(posedge aclk);
		key <= 1'b0;
		repeat (30) @(posedge aclk);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (30) @(posedge aclk);
		check(n_start, 32'h3);
		check(n_pulse, 32'h3);
		mkey <= 1'b1;
		repeat (6) @(posedge aclk);
		mkey <= 1'b0;
		rd(`MTS_A_CTRL);
		check({31'h0, rv[4]}, 32'h0);
		idle;
		$display("test external mode done");
	endtask
	task automatic t_timer;
		int n;
		wr(`MTS_A_TIMER, 32'h5);
		wr(`MTS_A_DELAY, 32'h1);
		wr(`MTS_A_TRIG, 32'h2);
		wr(`MTS_A_CTRL, 32'h4);
		wr(`MTS_A_CMD, 32'h1);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (start !== 1'b1 && n < 200);
		check({31'h0, n < 25}, 32'h1);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (start !== 1'b1 && n < 200);
		check({31'h0, n >= 45 && n < 200}, 32'h1);
		idle;
		$display("test timer done");
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{key, fire, chain, mco_q} = '0;
		{dio_n, mkey} = 2'b10;
		{awaddr, araddr, wdata} = '0;
		{n_start, n_pulse, n_wr, n_wr0} = '0;
		interlock = 1'b1;
		failures = 0;
		compares = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_defaults;
		t_source_a;
		t_samples;
		t_external;
		t_bus_manual;
		t_continuous;
		t_ext_mode;
		t_timer;
		summarize;
	end
	initial
	begin
		#400000;
		failures++;
		summarize;
	end
endmodule
`default_nettype wire
